// ### hw/rivm_top.sv
/*
  rivm_top: reset and interrupt vector address generator.
  assumes pending requests arrive already masked and enabled from the same clock,
  fuse and strap levels are stable during operation.
*/
// Functional notes
// - reset vector at word zero when fuse unprogrammed; two-word slots follow.
// - external requests zero to seven map to vectors 0x0002 through 0x0010.
// - timer vectors sit at 0x0012 through 0x0020.
// - serial, converter, eeprom, comparator vectors at 0x0022 through 0x002E.
// - extended vectors 0x0030 through 0x0044.
// - legacy mode suppresses vectors 0x0030 through 0x0044.
// - select bit adds boot section start to every interrupt vector.
// - programmed fuse starts execution at boot reset address.
// - four fuse and select combinations place reset and vectors.
// - fuse value one is unprogrammed, zero is programmed.
`timescale 1ns/1ps
module rivm_top
  import rivm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic boot_reset_select_fuse,
  input wire logic vector_table_in_boot_select,
  input wire logic legacy_mode,
  input wire logic [RIVM_ADDR_W-1:0] boot_reset_addr,
  input wire logic [RIVM_NUM_SRC-1:0] irq_pending,
  output logic [RIVM_ADDR_W-1:0] reset_vector,
  output logic [RIVM_ADDR_W-1:0] irq_vector,
  output logic irq_valid,
  output logic [RIVM_SRC_W-1:0] irq_source
);
  logic [RIVM_NUM_SRC-1:0] src_keep;
  logic [RIVM_NUM_SRC-1:0] pend_eff;
  logic [RIVM_SRC_W-1:0] pick;
  logic pick_any;
  logic [RIVM_ADDR_W-1:0] reloc_offset;

  // legacy suppression
  // extended sources exist only outside compatibility mode
  generate
    for (genvar g = 0; g < RIVM_NUM_SRC; g++) begin : g_src
      if (g < RIVM_NUM_BASE) begin : g_base
        assign src_keep[g] = 1'b1;
      end else begin : g_extd
        assign src_keep[g] = !legacy_mode;
      end
    end
  endgenerate

  always_comb begin
    pend_eff = irq_pending & src_keep;
  end

  always_comb begin
    pick = '0;
    pick_any = 1'b0;
    for (int i = RIVM_NUM_SRC - 1; i >= 0; i--) begin
      if (pend_eff[i]) begin
        pick = RIVM_SRC_W'(i);
        pick_any = 1'b1;
      end
    end
  end

  // relocation offset
  // zero offset keeps the plain table; sums wrap within 16 bits
  always_comb begin
    reloc_offset = '0;
    if (vector_table_in_boot_select) begin
      reloc_offset = boot_reset_addr;
    end
  end

  // lookup and relocation in one registered step
  rivm_vec_table u_table (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .src_index(pick),
    .offset(reloc_offset),
    .vec_addr(irq_vector)
  );

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_valid <= 1'b0;
    end else begin
      irq_valid <= pick_any;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_source <= '0;
    end else begin
      irq_source <= pick;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reset_vector <= RIVM_RESET_ADDR;
    end else begin
      reset_vector <= (boot_reset_select_fuse == RIVM_FUSE_PROGRAMMED) ?
                      boot_reset_addr : RIVM_RESET_ADDR;
    end
  end

  reset_place_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    boot_reset_select_fuse |=> reset_vector == RIVM_RESET_ADDR)
    else $error("reset vector not zero with fuse unprogrammed");
  boot_place_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    !boot_reset_select_fuse |=> reset_vector == $past(boot_reset_addr))
    else $error("reset vector not boot address");
  boot_both_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (!boot_reset_select_fuse && vector_table_in_boot_select && irq_pending[0])
    |=> (reset_vector == $past(boot_reset_addr)
    && irq_vector == $past(boot_reset_addr) + RIVM_VEC_BASE))
    else $error("boot reset with boot table wrong");

  vec_base_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (irq_pending[0] && !vector_table_in_boot_select) |=> irq_vector == RIVM_VEC_BASE)
    else $error("request zero vector wrong");
  ext_mid_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (irq_pending[3:0] == 4'h8 && !vector_table_in_boot_select) |=> irq_vector == 16'h0008)
    else $error("request three vector wrong");
  ext_last_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (irq_pending[7:0] == 8'h80 && !vector_table_in_boot_select) |=> irq_vector == RIVM_EXT_LAST)
    else $error("request seven vector wrong");
  timer_slot_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (irq_pending[8:0] == 9'h100 && !vector_table_in_boot_select) |=> irq_vector == RIVM_TIMER_BASE)
    else $error("timer vector wrong");
  timer_last_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (irq_pending[15:0] == 16'h8000 && !vector_table_in_boot_select) |=> irq_vector == 16'h0020)
    else $error("last timer vector wrong");
  serial_slot_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (irq_pending[16:0] == 17'h10000 && !vector_table_in_boot_select)
    |=> irq_vector == RIVM_SERIAL_BASE)
    else $error("serial vector wrong");
  base_last_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (irq_pending[22:0] == 23'h400000 && !vector_table_in_boot_select)
    |=> irq_vector == RIVM_BASE_LAST)
    else $error("comparator vector wrong");
  extd_first_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (irq_pending[23:0] == 24'h800000 && !legacy_mode && !vector_table_in_boot_select)
    |=> irq_vector == RIVM_EXTD_FIRST)
    else $error("first extended vector wrong");
  vec_last_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (irq_pending == 34'h200000000 && !legacy_mode && !vector_table_in_boot_select)
    |=> irq_vector == RIVM_EXTD_LAST)
    else $error("last vector wrong");
  source_vec_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (pick_any && !vector_table_in_boot_select)
    |=> irq_vector == RIVM_VEC_BASE + RIVM_VEC_STEP * 16'(irq_source))
    else $error("vector does not match source slot");

  legacy_hide_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (legacy_mode && irq_pending[RIVM_NUM_BASE-1:0] == '0) |=> !irq_valid)
    else $error("extended vector in legacy mode");
  legacy_keep_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (legacy_mode && irq_pending[22:0] == 23'h400000) |=> (irq_valid && irq_source == 6'h16))
    else $error("base vector lost in legacy mode");
  legacy_src_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    legacy_mode |=> (!irq_valid || irq_source < 6'(RIVM_NUM_BASE)))
    else $error("extended source chosen in legacy mode");

  reloc_add_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (vector_table_in_boot_select && irq_pending[0])
    |=> irq_vector == $past(boot_reset_addr) + RIVM_VEC_BASE)
    else $error("relocated vector wrong");
  reloc_last_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (vector_table_in_boot_select && !legacy_mode && irq_pending == 34'h200000000)
    |=> irq_vector == $past(boot_reset_addr) + RIVM_EXTD_LAST)
    else $error("relocated last vector wrong");

  prio_low_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (irq_pending[0] && irq_pending[5]) |=> irq_source == '0)
    else $error("priority wrong");
  prio_mid_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (irq_pending[5:0] == 6'h20) |=> irq_source == 6'h05)
    else $error("priority of source five wrong");
  one_cycle_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (|irq_pending[RIVM_NUM_BASE-1:0]) |=> irq_valid)
    else $error("vector not valid next cycle");
  idle_valid_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (irq_pending == '0) |=> !irq_valid)
    else $error("vector valid with nothing pending");

  // main scenarios
  cov_boot_c: cover property (@(posedge ref_clk) !boot_reset_select_fuse);
  cov_reloc_c: cover property (@(posedge ref_clk) vector_table_in_boot_select && pick_any);
  cov_legacy_c: cover property (@(posedge ref_clk) legacy_mode && irq_pending[33]);
  cov_prio_c: cover property (@(posedge ref_clk) irq_pending[5] && irq_pending[30]);
  cov_both_c: cover property (@(posedge ref_clk)
    !boot_reset_select_fuse && vector_table_in_boot_select);
endmodule

// ### hw/rivm_pkg.sv
/*
  rivm_pkg: constants for the reset and interrupt vector map.
  assumes word-addressed program flash of 64K words.
*/
package rivm_pkg;
  localparam int RIVM_ADDR_W = 16;
  localparam int RIVM_NUM_SRC = 34;
  localparam int RIVM_SRC_W = 6;
  localparam int RIVM_NUM_BASE = 23;
  localparam logic [15:0] RIVM_RESET_ADDR = 16'h0000;
  localparam logic [15:0] RIVM_VEC_BASE = 16'h0002;
  localparam logic [15:0] RIVM_VEC_STEP = 16'h0002;
  localparam logic [15:0] RIVM_EXT_LAST = 16'h0010;
  localparam logic [15:0] RIVM_TIMER_BASE = 16'h0012;
  localparam logic [15:0] RIVM_SERIAL_BASE = 16'h0022;
  localparam logic [15:0] RIVM_BASE_LAST = 16'h002E;
  localparam logic [15:0] RIVM_EXTD_FIRST = 16'h0030;
  localparam logic [15:0] RIVM_EXTD_LAST = 16'h0044;
  localparam logic [15:0] RIVM_BOOT_START_RST = 16'hF000;
  localparam logic RIVM_FUSE_PROGRAMMED = 1'b0;
  typedef enum logic [1:0] {
    rivm_idle_s = 2'b00,
    rivm_run_s = 2'b01
  } rivm_state_t;
endpackage

// ### hw/rivm_vec_table.sv
/*
  rivm_vec_table: registered vector address by source index, plus a relocation offset.
  assumes index 0 is the first interrupt source (vector number 2).
*/
`timescale 1ns/1ps
module rivm_vec_table
  import rivm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [RIVM_SRC_W-1:0] src_index,
  input wire logic [RIVM_ADDR_W-1:0] offset,
  output logic [RIVM_ADDR_W-1:0] vec_addr
);
  logic [RIVM_ADDR_W-1:0] next_vec_addr;
  always_comb begin
    // offset added here so the top output stays a flop
    next_vec_addr = RIVM_VEC_BASE + 16'({src_index, 1'b0}) + offset;
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      vec_addr <= RIVM_RESET_ADDR;
    end else begin
      vec_addr <= next_vec_addr;
    end
  end
endmodule

// ### verif/rivm_fetch_model.sv
/*
  rivm_fetch_model: program-counter load of the core beside the vector map.
  assumes vector outputs settle one edge after the map samples its inputs.
*/
`timescale 1ns/1ps
module rivm_fetch_model
  import rivm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic irq_valid,
  input wire logic [RIVM_ADDR_W-1:0] irq_vector,
  output logic [RIVM_ADDR_W-1:0] fetch_addr
);
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fetch_addr <= 16'h0000;
    end else if (irq_valid) begin
      fetch_addr <= irq_vector;
    end
  end
endmodule

// ### verif/tb.sv
/*
  tb: self-checking bench for rivm_top with a fetch model.
  assumes one cycle from sampled inputs to settled outputs.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module tb;
  import rivm_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic fuse = 1'b1;
  logic sel = 1'b0;
  logic legacy = 1'b0;
  logic [15:0] boot = 16'hF000;
  logic [33:0] pend = '0;
  logic [15:0] rst_v, irq_v, fetch;
  logic valid;
  logic [5:0] src;
  int err_count = 0;
  int checks_done = 0;
  rivm_top dut (.ref_clk(ref_clk), .rstn(rstn), .boot_reset_select_fuse(fuse),
    .vector_table_in_boot_select(sel), .legacy_mode(legacy), .boot_reset_addr(boot),
    .irq_pending(pend), .reset_vector(rst_v), .irq_vector(irq_v), .irq_valid(valid),
    .irq_source(src));
  rivm_fetch_model core (.ref_clk(ref_clk), .rstn(rstn), .irq_valid(valid),
    .irq_vector(irq_v), .fetch_addr(fetch));
  // inputs change at the falling edge so the rising edge sees them settled
  task automatic apply(input logic [33:0] p);
    pend = p;
    @(negedge ref_clk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic t_reset();
    fuse = 1'b0;
    apply('0);
    `CHK(rst_v, boot)
    fuse = 1'b1;
    apply('0);
    `CHK(rst_v, 16'h0000)
    `CHK(valid, 1'b0)
    $display("reset test done");
  endtask
  task automatic t_table();
    for (int i = 0; i < 34; i++) begin
      apply(34'h1 << i);
      `CHK(irq_v, RIVM_VEC_BASE + RIVM_VEC_STEP * 16'(i))
      `CHK(src, 6'(i))
    end
    $display("table test done");
  endtask
  task automatic t_legacy();
    legacy = 1'b1;
    apply(34'h1 << 23);
    `CHK(valid, 1'b0)
    apply((34'h1 << 33) | (34'h1 << 22));
    `CHK(irq_v, 16'h002E)
    legacy = 1'b0;
    $display("legacy test done");
  endtask
  task automatic t_reloc();
    sel = 1'b1;
    apply(34'h1);
    `CHK(irq_v, 16'hF002)
    apply(34'h1 << 33);
    `CHK(irq_v, 16'hF044)
    `CHK(rst_v, 16'h0000)
    fuse = 1'b0;
    boot = 16'hE000;
    apply(34'h1);
    `CHK(irq_v, 16'hE002)
    `CHK(rst_v, 16'hE000)
    fuse = 1'b1;
    boot = 16'hF000;
    sel = 1'b0;
    $display("relocation test done");
  endtask
  task automatic t_prio();
    apply(34'h21);
    `CHK(src, 6'h00)
    apply((34'h1 << 30) | (34'h1 << 5));
    `CHK(src, 6'h05)
    apply('0);
    `CHK(fetch, 16'h000C)
    `CHK(valid, 1'b0)
    $display("priority test done");
  endtask
  // async reset in mid-run: outputs drop at once, first edge after release answers
  task automatic t_midrst();
    fuse = 1'b0;
    apply(34'h1 << 3);
    `CHK(rst_v, boot)
    rstn = 1'b0;
    @(negedge ref_clk);
    `CHK({rst_v, irq_v, valid, src}, 39'h0)
    `CHK(fetch, 16'h0000)
    rstn = 1'b1;
    apply(34'h1 << 3);
    `CHK(irq_v, 16'h0008)
    `CHK(rst_v, boot)
    fuse = 1'b1;
    $display("mid-run reset test done");
  endtask
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  // bounded run: a hang is cut short and counted
  initial begin
    #1000000;
    err_count++;
    conclude();
  end
  initial begin
    repeat (2) @(negedge ref_clk);
    rstn = 1'b1;
    t_reset();
    t_table();
    t_legacy();
    t_reloc();
    t_prio();
    t_midrst();
    conclude();
  end
endmodule
